// ---- iso_rx_context_control.sv ----
// Isochronous receive context control: AHB-Lite register file and four context engines.
// Operation
// - Four contexts; control set at 400h, clear at 404h, stepping 32 bytes.
// - Packing on fills buffers back to back; off gives one packet per buffer.
// - Header retention keeps the 4-byte header and appends status plus time tag.
// - Without retention the header is stripped; a kept header precedes payload.
// - Cycle-matched start begins running when target cycle equals received cycle count.
// - Hardware clears the cycle-matched start bit once the context is active.
// - Many-channel receive accepts every masked channel, ignoring the match channel.
// - Otherwise only the single programmed match channel is accepted.
// - Split payload mode routes leading and trailing parts to separate buffer series.
// - Split payload mode forces many-channel and packing bits to zero.
// - Split payload bit ignores writes while active or run is one.
// - Run is software owned; hardware changes it only on reset.
// - Resume is set by software and cleared on each descriptor fetch unless software sets it in the same cycle.
// - Fatal error while run is set sets dead, run clear clears it; active shows processing.
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
module iso_rx_context_control #(
    parameter int NUM_CTX = iso_rx_pkg::NUM_CTX,
    parameter int BUF_WORDS = iso_rx_pkg::BUF_WORDS,
    parameter int LEADING_WORDS = iso_rx_pkg::LEADING_WORDS
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic soft_reset,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Packet stream from the link layer.
    input wire logic pkt_valid,
    input wire logic pkt_first,
    input wire logic pkt_last,
    input wire logic [31:0] pkt_data,
    input wire logic [5:0] pkt_channel,
    input wire logic [2:0] pkt_speed,
    output logic pkt_ready,
    // Cycle start information.
    input wire logic cycle_start,
    input wire logic [12:0] cycle_count,
    input wire logic [15:0] cycle_time_tag,
    // Matching setup (one channel mask shared by all contexts) and per-context descriptor events.
    input wire logic [NUM_CTX*6-1:0] match_channel,
    input wire logic [NUM_CTX*13-1:0] target_cycle_number,
    input wire logic [63:0] channel_mask,
    input wire logic [NUM_CTX-1:0] desc_fetch,
    input wire logic [NUM_CTX-1:0] fatal_error,
    // Payload stream toward the DMA writer.
    output logic dma_valid,
    output logic [31:0] dma_data,
    output logic [1:0] dma_context,
    output logic dma_part,
    output logic dma_close
);
    // Bits software may set or clear through the set and clear addresses.
    localparam logic [31:0] SW_MASK = 32'hf800_9000;

    logic [31:0] ctrl_r [NUM_CTX];
    logic [31:0] ctrl_nxt [NUM_CTX];
    logic [31:0] rd_view [NUM_CTX];
    logic wr_pend_r;
    logic rd_wait_r;
    logic [11:0] dph_addr_r;
    logic [31:0] hrdata_r;

    ctx_ctrl_if cif [NUM_CTX] ();

    // Map a register offset to its context number and a hit flag for either the set or the clear address.
    function automatic logic [2:0] decode_ofs(input logic [11:0] ofs);
        logic [11:0] rel;
        logic hit;
        rel = ofs - iso_rx_pkg::CTRL_SET_OFS;
        hit = (ofs >= iso_rx_pkg::CTRL_SET_OFS) && (rel[11:7] == 5'h00) && (rel[4:3] == 2'h0) && (rel[1:0] == 2'h0);
        decode_ofs = {hit && (rel[2] == 1'b0 || rel[2] == 1'b1), rel[6:5]};
    endfunction

    // Address phase capture and data phase decode.
    wire aph_valid = hsel && hready && (htrans == iso_rx_pkg::HTRANS_NONSEQ || htrans == iso_rx_pkg::HTRANS_SEQ);
    wire [2:0] dph_dec = decode_ofs(dph_addr_r);
    wire dph_hit = dph_dec[2];
    wire [1:0] dph_ctx = dph_dec[1:0];
    wire dph_is_clr = dph_addr_r[2];
    wire do_write = wr_pend_r && dph_hit;

    // AHB pipeline: writes finish with no wait, reads take one wait state.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_wait_r <= 1'b0;
            dph_addr_r <= 12'h000;
        end else if (hreadyout) begin
            wr_pend_r <= aph_valid && hwrite;
            rd_wait_r <= aph_valid && !hwrite;
            if (aph_valid) begin
                dph_addr_r <= haddr[11:0];
            end
        end else begin
            rd_wait_r <= 1'b0;
        end
    end

    // Read data is sampled in the wait state, after any earlier write has landed.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (rd_wait_r) begin
            hrdata_r <= dph_hit ? rd_view[dph_ctx] : 32'h0000_0000;
        end
    end

    assign hreadyout = !rd_wait_r;
    assign hrdata = hrdata_r;
    assign hresp = 1'b0;

    // Per-context control register update and engine hookup.
    for (genvar n = 0; n < NUM_CTX; n++) begin : g_ctx
        wire sel = do_write && (dph_ctx == 2'(n));
        wire busy = ctrl_r[n][iso_rx_pkg::RUN_BIT] || ctrl_r[n][iso_rx_pkg::ACTIVE_BIT];
        wire [31:0] wmask = busy ? (SW_MASK & ~(32'h1 << iso_rx_pkg::SPLIT_BIT)) : SW_MASK;
        wire [31:0] set_v = (sel && !dph_is_clr) ? (hwdata & wmask) : 32'h0000_0000;
        wire [31:0] clr_v = (sel && dph_is_clr) ? (hwdata & wmask) : 32'h0000_0000;
        wire [31:0] sw_v = (ctrl_r[n] | set_v) & ~clr_v;
        wire run_clr = ctrl_r[n][iso_rx_pkg::RUN_BIT] && !sw_v[iso_rx_pkg::RUN_BIT];

        // Hardware updates; a set wins over a same-cycle clear for resume and dead, while a hardware clear wins for the other bits.
        always_comb begin
            ctrl_nxt[n] = sw_v;
            if (sw_v[iso_rx_pkg::SPLIT_BIT]) begin
                ctrl_nxt[n][iso_rx_pkg::MULTI_BIT] = 1'b0;
                ctrl_nxt[n][iso_rx_pkg::PACK_BIT] = 1'b0;
            end
            if (cif[n].active) begin
                ctrl_nxt[n][iso_rx_pkg::CYC_BIT] = 1'b0;
            end
            if (desc_fetch[n] && !set_v[iso_rx_pkg::RESUME_BIT]) begin
                ctrl_nxt[n][iso_rx_pkg::RESUME_BIT] = 1'b0;
            end
            if (run_clr) begin
                ctrl_nxt[n][iso_rx_pkg::DEAD_BIT] = 1'b0;
            end
            if (fatal_error[n] && ctrl_r[n][iso_rx_pkg::RUN_BIT]) begin
                ctrl_nxt[n][iso_rx_pkg::DEAD_BIT] = 1'b1;
            end
            ctrl_nxt[n][iso_rx_pkg::ACTIVE_BIT] = cif[n].active;
            if (cif[n].rx_done) begin
                ctrl_nxt[n][iso_rx_pkg::SPD_LSB +: 3] = cif[n].spd;
                ctrl_nxt[n][iso_rx_pkg::EVT_LSB +: 5] = cif[n].evt;
            end
        end

        // Run is touched only by software and the two resets.
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                ctrl_r[n] <= iso_rx_pkg::CTRL_RESET;
            end else if (soft_reset) begin
                ctrl_r[n] <= iso_rx_pkg::CTRL_RESET;
            end else begin
                ctrl_r[n] <= ctrl_nxt[n];
            end
        end

        // Reserved bits 26..13 except run, and 9..8, always read zero.
        assign rd_view[n] = ctrl_r[n] & 32'hf800_9cff;

        assign cif[n].run = ctrl_r[n][iso_rx_pkg::RUN_BIT];
        assign cif[n].packing = ctrl_r[n][iso_rx_pkg::PACK_BIT];
        assign cif[n].keep_hdr = ctrl_r[n][iso_rx_pkg::HDR_BIT];
        assign cif[n].start_on_cycle = ctrl_r[n][iso_rx_pkg::CYC_BIT];
        assign cif[n].many_ch = ctrl_r[n][iso_rx_pkg::MULTI_BIT];
        assign cif[n].split = ctrl_r[n][iso_rx_pkg::SPLIT_BIT];
        assign cif[n].dead = ctrl_r[n][iso_rx_pkg::DEAD_BIT];

        rx_context_engine #(
            .BUF_WORDS(BUF_WORDS),
            .LEADING_WORDS(LEADING_WORDS)
        ) u_engine (
            .hclk(hclk),
            .hresetn(hresetn),
            .c(cif[n]),
            .pkt_valid(pkt_valid),
            .pkt_first(pkt_first),
            .pkt_last(pkt_last),
            .pkt_data(pkt_data),
            .pkt_channel(pkt_channel),
            .pkt_speed(pkt_speed),
            .cycle_start(cycle_start),
            .cycle_count(cycle_count),
            .cycle_time_tag(cycle_time_tag),
            .match_channel(match_channel[n*6 +: 6]),
            .target_cycle_number(target_cycle_number[n*13 +: 13]),
            .channel_mask(channel_mask)
        );
    end

    // Flatten engine outputs so the merge below can index them.
    logic [NUM_CTX-1:0] ov;
    logic [NUM_CTX-1:0] rdy;
    logic [31:0] od [NUM_CTX];
    logic [NUM_CTX-1:0] opart;
    logic [NUM_CTX-1:0] oclose;
    for (genvar k = 0; k < NUM_CTX; k++) begin : g_flat
        assign ov[k] = cif[k].out_valid;
        assign rdy[k] = cif[k].ready;
        assign od[k] = cif[k].out_data;
        assign opart[k] = cif[k].out_part;
        assign oclose[k] = cif[k].out_close;
    end

    // The lowest numbered context wins when two emit in one cycle; with distinct
    // channels per context, as software is expected to set up, this never happens.
    always_comb begin
        dma_valid = 1'b0;
        dma_data = 32'h0000_0000;
        dma_context = 2'h0;
        dma_part = 1'b0;
        dma_close = 1'b0;
        for (int i = NUM_CTX - 1; i >= 0; i--) begin
            if (ov[i]) begin
                dma_valid = 1'b1;
                dma_data = od[i];
                dma_context = 2'(i);
                dma_part = opart[i];
                dma_close = oclose[i];
            end
        end
    end

    // A trailer being appended stalls the link for one cycle.
    assign pkt_ready = &rdy;
endmodule

// ---- iso_rx_pkg.sv ----
// Shared constants for the isochronous receive context control block.
package iso_rx_pkg;
    // Context count and register map.
    localparam int NUM_CTX = 4;
    localparam logic [11:0] CTRL_SET_OFS = 12'h400;
    localparam logic [11:0] CTRL_CLR_OFS = 12'h404;
    localparam logic [11:0] CTX_STRIDE = 12'h020;
    localparam int CTX_SEL_LSB = 5;
    // Control register field positions.
    localparam int PACK_BIT = 31;
    localparam int HDR_BIT = 30;
    localparam int CYC_BIT = 29;
    localparam int MULTI_BIT = 28;
    localparam int SPLIT_BIT = 27;
    localparam int RUN_BIT = 15;
    localparam int RESUME_BIT = 12;
    localparam int DEAD_BIT = 11;
    localparam int ACTIVE_BIT = 10;
    localparam int SPD_LSB = 5;
    localparam int EVT_LSB = 0;
    // Value after reset; undefined fields are given zero.
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Speed codes.
    localparam logic [2:0] SPD_100 = 3'h0;
    localparam logic [2:0] SPD_200 = 3'h1;
    localparam logic [2:0] SPD_400 = 3'h2;
    // Event code written when a packet completes cleanly.
    localparam logic [4:0] EVT_COMPLETE = 5'h01;
    // Default buffer geometry in words.
    localparam int BUF_WORDS = 16;
    localparam int LEADING_WORDS = 2;
    // AHB encodings.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage

// ---- ctx_ctrl_if.sv ----
// Control and status bundle between the register file and one receive context engine.
`timescale 1ns/1ps
interface ctx_ctrl_if;
    logic run;
    logic packing;
    logic keep_hdr;
    logic start_on_cycle;
    logic many_ch;
    logic split;
    logic dead;
    logic active;
    logic rx_done;
    logic [2:0] spd;
    logic [4:0] evt;
    logic ready;
    logic out_valid;
    logic [31:0] out_data;
    logic out_part;
    logic out_close;
    modport engine (
        input run, packing, keep_hdr, start_on_cycle, many_ch, split, dead,
        output active, rx_done, spd, evt, ready, out_valid, out_data, out_part, out_close
    );
    modport regs (
        output run, packing, keep_hdr, start_on_cycle, many_ch, split, dead,
        input active, rx_done, spd, evt, ready, out_valid, out_data, out_part, out_close
    );
endinterface

// ---- rx_context_engine.sv ----
// One isochronous receive context: channel filter, cycle-matched start and payload formatting.
`timescale 1ns/1ps
module rx_context_engine #(
    parameter int BUF_WORDS = iso_rx_pkg::BUF_WORDS,
    parameter int LEADING_WORDS = iso_rx_pkg::LEADING_WORDS
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Register side.
    ctx_ctrl_if.engine c,
    // Packet stream from the link layer.
    input wire logic pkt_valid,
    input wire logic pkt_first,
    input wire logic pkt_last,
    input wire logic [31:0] pkt_data,
    input wire logic [5:0] pkt_channel,
    input wire logic [2:0] pkt_speed,
    // Cycle start information.
    input wire logic cycle_start,
    input wire logic [12:0] cycle_count,
    input wire logic [15:0] cycle_time_tag,
    // Matching setup held outside this block.
    input wire logic [5:0] match_channel,
    input wire logic [12:0] target_cycle_number,
    input wire logic [63:0] channel_mask
);
    logic active_r;
    logic in_pkt_r;
    logic trailer_r;
    logic [15:0] word_idx_r;
    logic [15:0] buf_cnt_r;
    logic [2:0] spd_r;
    logic done_r;
    logic out_valid_r;
    logic [31:0] out_data_r;
    logic out_part_r;
    logic out_close_r;

    // Channel filter and start condition.
    wire chan_hit = c.many_ch ? channel_mask[pkt_channel] : (pkt_channel == match_channel);
    wire cyc_hit = cycle_start && (cycle_count == target_cycle_number);
    wire start_ok = c.run && !c.dead && !active_r && (!c.start_on_cycle || cyc_hit);
    wire take_first = pkt_valid && pkt_first && active_r && chan_hit && !trailer_r;
    wire take_word = pkt_valid && in_pkt_r && !pkt_first && !trailer_r;
    wire take_any = take_first || take_word;
    // The header is stored only when retained; the payload always.
    wire emit_word = take_word || (take_first && c.keep_hdr);
    wire pkt_end = take_any && pkt_last;
    wire [31:0] trailer_word = {{8{1'b0}}, spd_r, iso_rx_pkg::EVT_COMPLETE, cycle_time_tag};
    // Payload words past the leading count go to the trailing buffer series.
    wire part_sel = c.split && take_word && (word_idx_r >= 16'(LEADING_WORDS));
    wire buf_full = (buf_cnt_r == 16'(BUF_WORDS - 1));
    wire word_close = c.packing ? buf_full : (pkt_end && !c.keep_hdr);
    wire emit_any = emit_word || trailer_r;
    wire close_any = trailer_r ? (c.packing ? buf_full : 1'b1) : word_close;

    // Context active state; it ends when run is cleared or on a fatal error.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_r <= 1'b0;
        end else if (!c.run || c.dead) begin
            active_r <= 1'b0;
        end else if (start_ok) begin
            active_r <= 1'b1;
        end
    end

    // Packet framing and trailer sequencing.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_pkt_r <= 1'b0;
            trailer_r <= 1'b0;
            word_idx_r <= 16'h0000;
            spd_r <= iso_rx_pkg::SPD_100;
            done_r <= 1'b0;
        end else begin
            done_r <= pkt_end;
            trailer_r <= pkt_end && c.keep_hdr;
            if (take_first) begin
                spd_r <= pkt_speed;
                word_idx_r <= 16'h0000;
            end else if (take_word) begin
                word_idx_r <= word_idx_r + 16'h0001;
            end
            if (pkt_end || !active_r) begin
                in_pkt_r <= 1'b0;
            end else if (take_first) begin
                in_pkt_r <= 1'b1;
            end
        end
    end

    // Buffer fill count and registered output word.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            buf_cnt_r <= 16'h0000;
            out_valid_r <= 1'b0;
            out_data_r <= 32'h0000_0000;
            out_part_r <= 1'b0;
            out_close_r <= 1'b0;
        end else begin
            out_valid_r <= emit_any;
            out_close_r <= emit_any && close_any;
            if (emit_any) begin
                out_data_r <= trailer_r ? trailer_word : pkt_data;
                out_part_r <= part_sel;
                buf_cnt_r <= close_any ? 16'h0000 : buf_cnt_r + 16'h0001;
            end
        end
    end

    // Status toward the register file.
    assign c.active = active_r;
    assign c.rx_done = done_r;
    assign c.spd = spd_r;
    assign c.evt = iso_rx_pkg::EVT_COMPLETE;
    assign c.ready = !trailer_r;
    assign c.out_valid = out_valid_r;
    assign c.out_data = out_data_r;
    assign c.out_part = out_part_r;
    assign c.out_close = out_close_r;
endmodule

// ---- iso_rx_ctrl_assertions.sv ----
// Concurrent checks on the ports of the receive context control block.
`timescale 1ns/1ps
module iso_rx_ctrl_checker (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Register bus.
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // Link and payload streams.
    input wire logic pkt_valid,
    input wire logic pkt_first,
    input wire logic pkt_last,
    input wire logic [31:0] pkt_data,
    input wire logic [2:0] pkt_speed,
    input wire logic pkt_ready,
    input wire logic [15:0] cycle_time_tag,
    input wire logic dma_valid,
    input wire logic [31:0] dma_data
);
    logic [2:0] spd_r;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Speed of the packet in flight, kept because the trailer reports it after the header is gone.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            spd_r <= 3'h0;
        end else if (pkt_valid && pkt_ready && pkt_first) begin
            spd_r <= pkt_speed;
        end
    end
    // Accepted bus requests and accepted link words.
    sequence s_rd_req; hsel && hready && htrans[1] && !hwrite; endsequence
    sequence s_wr_req; hsel && hready && htrans[1] && hwrite; endsequence
    sequence s_rd_answer; !hreadyout ##1 hreadyout; endsequence
    property p_rd_wait; s_rd_req |=> s_rd_answer; endproperty
    property p_wr_nowait; s_wr_req |=> hreadyout; endproperty
    property p_okay; hresp == 1'b0; endproperty
    property p_ready_gap; !pkt_ready |-> $past(pkt_valid && pkt_ready && pkt_last); endproperty
    property p_ready_one; !pkt_ready |=> pkt_ready; endproperty
    property p_dma_cause; dma_valid |-> $past(pkt_valid && pkt_ready) || !$past(pkt_ready); endproperty
    property p_payload; dma_valid && $past(pkt_valid && pkt_ready) |-> dma_data == $past(pkt_data); endproperty
    property p_trailer;
        dma_valid && !$past(pkt_ready) |-> dma_data == {8'h00, spd_r, iso_rx_pkg::EVT_COMPLETE, cycle_time_tag};
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read answer timing wrong");
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    a_okay: assert property (p_okay) else $error("bus response not okay");
    a_ready_gap: assert property (p_ready_gap) else $error("link stalled without a last word");
    a_ready_one: assert property (p_ready_one) else $error("link stalled too long");
    a_dma_cause: assert property (p_dma_cause) else $error("payload word without a cause");
    a_payload: assert property (p_payload) else $error("payload word altered");
    a_trailer: assert property (p_trailer) else $error("trailer word wrong");
endmodule
bind iso_rx_context_control iso_rx_ctrl_checker u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .pkt_valid(pkt_valid), .pkt_first(pkt_first),
    .pkt_last(pkt_last), .pkt_data(pkt_data), .pkt_speed(pkt_speed), .pkt_ready(pkt_ready),
    .cycle_time_tag(cycle_time_tag), .dma_valid(dma_valid), .dma_data(dma_data)
);

// ---- link_model.sv ----
// Link layer model that feeds isochronous packets to the block word by word.
`timescale 1ns/1ps
module link_model (
    // Clock and handshake.
    input wire logic hclk,
    input wire logic pkt_ready,
    // Packet stream.
    output logic pkt_valid = 1'b0,
    output logic pkt_first = 1'b0,
    output logic pkt_last = 1'b0,
    output logic [31:0] pkt_data = 32'h0,
    output logic [5:0] pkt_channel = 6'h0,
    output logic [2:0] pkt_speed = 3'h0
);
    logic rdy_n = 1'b1;
    // Ready is sampled mid-cycle so the value seen is the one present at the next rising edge.
    always @(negedge hclk) rdy_n = pkt_ready;
    // Header word is base, payload word i is base plus i; the word stays until ready is seen.
    task automatic send(input logic [5:0] ch, input logic [2:0] spd, input int n, input logic [31:0] base);
        for (int i = 0; i <= n; i++) begin
            pkt_valid <= 1'b1;
            pkt_first <= (i == 0);
            pkt_last <= (i == n);
            pkt_data <= base + 32'(i);
            pkt_channel <= ch;
            pkt_speed <= spd;
            do @(posedge hclk); while (!rdy_n);
        end
        // Released data, channel and speed lines show the inverse so stale values are never mistaken for live ones.
        pkt_valid <= 1'b0;
        pkt_first <= 1'b0;
        pkt_last <= 1'b0;
        pkt_data <= ~(base + 32'(n));
        pkt_channel <= ~ch;
        pkt_speed <= ~spd;
    endtask
endmodule

// ---- iso_rx_context_control_tb.sv ----
// Self-checking testbench for the receive context control block.
`timescale 1ns/1ps
module iso_rx_context_control_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic soft_reset = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, pkt_ready, pkt_valid, pkt_first, pkt_last, dma_valid, dma_part, dma_close;
    logic [31:0] pkt_data, dma_data, q;
    logic [5:0] pkt_channel;
    logic [2:0] pkt_speed;
    logic [1:0] dma_context;
    logic cycle_start = 1'b0;
    logic [12:0] cycle_count = 13'h0;
    logic [15:0] cycle_time_tag = 16'h5a3c;
    logic [23:0] match_channel = {6'h05, 6'h00, 6'h07, 6'h06};
    logic [51:0] target_cycle_number = {13'h0123, 39'h0};
    logic [63:0] channel_mask = 64'h200;
    logic [3:0] desc_fetch = 4'h0;
    logic [3:0] fatal_error = 4'h0;
    logic rdy_n = 1'b1;
    logic [31:0] rd_n = 32'h0;
    logic [35:0] got[$];
    logic [35:0] exp[$];
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    always #4 hclk = ~hclk;
    iso_rx_context_control DUT (
        .hclk(hclk), .hresetn(hresetn), .soft_reset(soft_reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pkt_valid(pkt_valid),
        .pkt_first(pkt_first), .pkt_last(pkt_last), .pkt_data(pkt_data), .pkt_channel(pkt_channel),
        .pkt_speed(pkt_speed), .pkt_ready(pkt_ready), .cycle_start(cycle_start), .cycle_count(cycle_count),
        .cycle_time_tag(cycle_time_tag), .match_channel(match_channel),
        .target_cycle_number(target_cycle_number), .channel_mask(channel_mask), .desc_fetch(desc_fetch),
        .fatal_error(fatal_error), .dma_valid(dma_valid), .dma_data(dma_data), .dma_context(dma_context),
        .dma_part(dma_part), .dma_close(dma_close)
    );
    link_model link (
        .hclk(hclk), .pkt_ready(pkt_ready), .pkt_valid(pkt_valid), .pkt_first(pkt_first),
        .pkt_last(pkt_last), .pkt_data(pkt_data), .pkt_channel(pkt_channel), .pkt_speed(pkt_speed)
    );
    // Bus answers are sampled mid-cycle, which is the value present at the following rising edge.
    always @(negedge hclk) begin
        rdy_n = hreadyout;
        rd_n = hrdata;
    end
    // Every payload word leaving the block is collected for later comparison.
    always @(posedge hclk) begin
        cycles++;
        if (dma_valid === 1'b1) got.push_back({dma_close, dma_part, dma_context, dma_data});
        if (cycles == 5000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [35:0] e, input logic [35:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask
    // One single AHB-Lite transfer; returns read data taken at the end of the data phase.
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= iso_rx_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (!rdy_n);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (!rdy_n);
        q = rd_n;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk("ctrl", {4'h0, e}, {4'h0, q});
    endtask
    function automatic logic [31:0] sa(input int n, input int clr);
        return 32'h400 + 32'(n * 32 + clr * 4);
    endfunction
    task automatic pulse(input logic [3:0] df, input logic [3:0] fe, input logic cs, input logic [12:0] cc);
        desc_fetch <= df;
        fatal_error <= fe;
        cycle_start <= cs;
        cycle_count <= cc;
        @(posedge hclk);
        desc_fetch <= 4'h0;
        fatal_error <= 4'h0;
        cycle_start <= 1'b0;
        @(posedge hclk);
    endtask
    // Sends one packet and compares what leaves toward the DMA writer.
    task automatic pkt(input logic [5:0] ch, input logic [2:0] spd, input int n, input logic [31:0] b);
        logic [35:0] g;
        got.delete();
        link.send(ch, spd, n, b);
        repeat (5) @(posedge hclk);
        chk("dma count", 36'(exp.size()), 36'(got.size()));
        while (exp.size() > 0 && got.size() > 0) begin
            g = got.pop_front();
            chk("dma word", exp.pop_front(), g);
        end
        exp.delete();
    endtask
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int n = 0; n < 4; n++) begin
            rd(sa(n, 0), 32'h0);
            rd(sa(n, 1), 32'h0);
        end
        ahb(1'b1, 32'h480, 32'hffff_ffff);
        rd(32'h480, 32'h0);
        rd(32'h408, 32'h0);
        ahb(1'b1, sa(0, 0), 32'hd000_6fff);
        rd(sa(0, 1), 32'hd000_0000);
        ahb(1'b1, sa(0, 1), 32'h4000_0000);
        rd(sa(0, 0), 32'h9000_0000);
        ahb(1'b1, sa(1, 0), 32'h9800_0000);
        rd(sa(1, 0), 32'h0800_0000);
        ahb(1'b1, sa(1, 0), 32'h9000_0000);
        rd(sa(1, 0), 32'h0800_0000);
        ahb(1'b1, sa(1, 0), 32'h0000_8000);
        rd(sa(1, 0), 32'h0800_8000);
        ahb(1'b1, sa(1, 1), 32'h0800_0000);
        rd(sa(1, 0), 32'h0800_8400);
        ahb(1'b1, sa(2, 0), 32'h0000_9000);
        rd(sa(2, 0), 32'h0000_9000);
        pulse(4'h4, 4'h0, 1'b0, 13'h0);
        rd(sa(2, 0), 32'h0000_8400);
        pulse(4'h0, 4'h4, 1'b0, 13'h0);
        rd(sa(2, 0), 32'h0000_8800);
        ahb(1'b1, sa(2, 1), 32'h0000_8000);
        rd(sa(2, 0), 32'h0);
        ahb(1'b1, sa(3, 0), 32'h6000_8000);
        rd(sa(3, 0), 32'h6000_8000);
        pulse(4'h0, 4'h0, 1'b1, 13'h0122);
        rd(sa(3, 0), 32'h6000_8000);
        pulse(4'h0, 4'h0, 1'b1, 13'h0123);
        rd(sa(3, 0), 32'h4000_8400);
        ahb(1'b1, sa(0, 0), 32'h0000_8000);
        rd(sa(0, 0), 32'h9000_8000);
        exp = '{{4'h0, 32'h1000_0001}, {4'h0, 32'h1000_0002}};
        pkt(6'h09, 3'h1, 2, 32'h1000_0000);
        exp = '{{4'h3, 32'h3000_0000}, {4'h3, 32'h3000_0001}, {4'h3, 32'h3000_0002}, {4'hb, 32'h0041_5a3c}};
        pkt(6'h05, 3'h2, 2, 32'h3000_0000);
        rd(sa(3, 0), 32'h4000_8441);
        pkt(6'h06, 3'h0, 1, 32'h4000_0000);
        exp = '{{4'h1, 32'h2000_0001}, {4'h1, 32'h2000_0002}, {4'hd, 32'h2000_0003}};
        pkt(6'h07, 3'h0, 3, 32'h2000_0000);
        soft_reset <= 1'b1;
        @(posedge hclk);
        soft_reset <= 1'b0;
        @(posedge hclk);
        rd(sa(3, 0), 32'h0);
        rd(sa(1, 1), 32'h0);
        end_of_test();
    end
endmodule
